// File: inc/cadir_pkg.sv
package cadir_pkg;
  // ***********************************
  // Address map bounds (inclusive)
  // ***********************************
  localparam logic [31:0] NVM_LO    = 32'h0000_0000;
  localparam logic [31:0] NVM_HI    = 32'h001F_FFFF;
  localparam logic [31:0] TCM_LO    = 32'h1000_0000;
  localparam logic [31:0] TCM_HI    = 32'h1005_FFFF;
  localparam logic [31:0] SRAM_LO   = 32'h1006_0000;
  localparam logic [31:0] SRAM_HI   = 32'h1015_FFFF;
  localparam logic [31:0] XSRAM_LO  = 32'h1016_0000;
  localparam logic [31:0] XSRAM_HI  = 32'h101D_7FFF;
  localparam logic [31:0] RSVD_LO   = 32'h2000_0000;
  localparam logic [31:0] RSVD_HI   = 32'h3FFF_FFFF;
  localparam logic [31:0] PERI_LO   = 32'h4000_0000;
  localparam logic [31:0] PERI_HI   = 32'h5FFF_FFFF;
  localparam logic [31:0] APB_LO    = 32'h4000_0000;
  localparam logic [31:0] APB_HI    = 32'h4007_FFFF;
  localparam logic [31:0] EXTM_LO   = 32'h6000_0000;
  localparam logic [31:0] EXTM_HI   = 32'h9FFF_FFFF;
  localparam logic [31:0] EXTD_LO   = 32'hA000_0000;
  localparam logic [31:0] EXTD_HI   = 32'hDFFF_FFFF;
  localparam logic [31:0] PPB_LO    = 32'hE000_0000;
  localparam logic [31:0] PPB_HI    = 32'hE004_3FFF;
  localparam logic [31:0] EXTERNAL_PRIVATE_PERIPH_BUS_LO   = 32'hE004_4000;
  localparam logic [31:0] EXTERNAL_PRIVATE_PERIPH_BUS_HI   = 32'hE00F_FFFF;
  localparam logic [31:0] VSYS_LO   = 32'hE010_0000;
  localparam logic [31:0] VSYS_HI   = 32'hFFFF_FFFF;
  localparam logic [31:0] VTOR_MASK = 32'hFFFF_FF80;
  localparam logic [31:0] VTOR_RST  = 32'h0000_0000;
  // ***********************************
  // Sizes, fault bits, clock modes
  // ***********************************
  localparam int NUM_IRQ   = 32;
  localparam int IRQ_IDW   = 5;
  localparam int PRIO_W    = 3;
  localparam int MPU_NREG  = 8;
  localparam int NUM_WATCH = 4;
  localparam int NUM_BRK   = 8;
  localparam int VEC_RSVD  = 16;
  localparam int APB_WAITS = 1;
  localparam int FS_XN     = 0;
  localparam int FS_MPU    = 1;
  localparam int FS_SYS    = 2;
  localparam int FS_BUS    = 3;
  localparam int FS_W      = 4;
  localparam logic [7:0] LP_MHZ = 8'h60;
  localparam logic [7:0] HP_MHZ = 8'hC0;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_NVM, TGT_TCM, TGT_SRAM, TGT_XSRAM, TGT_PERIPH, TGT_EXTMEM,
    TGT_EXTDEV, TGT_CORE_PPB, TGT_EXTERNAL_PRIVATE_PERIPH_BUS, TGT_SYSAHB
  } cadir_target_t;

  typedef enum {ST_IDLE, ST_WAIT, ST_RESP} cadir_state_t;

  // Inclusive range test shared by the map and the checks
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction
endpackage

// File: logic/cadir_addr_map.sv
`timescale 1ns/1ns
module cadir_addr_map
  import cadir_pkg::*;
(
  input  wire logic [31:0]             addr,
  output cadir_pkg::cadir_target_t     target,
  output logic                         exec_ok,
  output logic                         cacheable,
  output logic                         apb_slow
);
  // ***********************************
  // Region decode
  // ***********************************
  // Pure decode; the caller registers the result
  always_comb begin
    target    = TGT_NONE;
    exec_ok   = 1'b0;
    cacheable = 1'b0;
    apb_slow  = 1'b0;
    if (in_rng(addr, NVM_LO, NVM_HI)) begin
      target    = TGT_NVM;
      exec_ok   = 1'b1;
      cacheable = 1'b1; // [R19]
    end else if (in_rng(addr, TCM_LO, TCM_HI)) begin
      target  = TGT_TCM; // [R19]
      exec_ok = 1'b1;
    end else if (in_rng(addr, SRAM_LO, SRAM_HI)) begin
      target  = TGT_SRAM; // [R20]
      exec_ok = 1'b1;
    end else if (in_rng(addr, XSRAM_LO, XSRAM_HI)) begin
      target  = TGT_XSRAM; // [R20]
      exec_ok = 1'b1;
    end else if (in_rng(addr, PERI_LO, PERI_HI)) begin
      target   = TGT_PERIPH; // [R1]
      apb_slow = in_rng(addr, APB_LO, APB_HI); // [R21]
    end else if (in_rng(addr, EXTM_LO, EXTM_HI)) begin
      target  = TGT_EXTMEM; // [R2]
      exec_ok = 1'b1;
    end else if (in_rng(addr, EXTD_LO, EXTD_HI)) begin
      target = TGT_EXTDEV;
    end else if (in_rng(addr, PPB_LO, PPB_HI)) begin
      target = TGT_CORE_PPB; // [R3]
    end else if (in_rng(addr, EXTERNAL_PRIVATE_PERIPH_BUS_LO, EXTERNAL_PRIVATE_PERIPH_BUS_HI)) begin
      target = TGT_EXTERNAL_PRIVATE_PERIPH_BUS; // [R4]
    end else if (in_rng(addr, VSYS_LO, VSYS_HI)) begin
      target = TGT_SYSAHB; // [R7]
    end
    // Reserved and code-region holes stay TGT_NONE: bus error [R22]
  end
endmodule // cadir_addr_map

// File: logic/cadir_route.sv
`timescale 1ns/1ns
// Function
// [R1] Peripheral range routed, never executable
// [R2] External memory range routed, executable
// [R3] Core-local range never forwarded externally
// [R4] Upper private range goes to APB port
// [R5] Vector table stays outside private range; vec_base_reg takes any vec_base_data masked by VTOR_MASK, with no range check
// [R6] Fetch from private/vendor range faults
// [R7] Vendor range data goes to system AHB
// [R8] Each interrupt fans out to both controllers
// [R9] Any interrupt wakes core from deep sleep
// [R10] No non-maskable interrupt source exists
// [R11] Exactly eight priority levels per source
// [R12] Vector table base relocatable by software
// [R13] Eight protection regions fault unprivileged access
// [R14] Fault cause kept in status register
// [R15] Core and system protection both checked
// [R16] 96 MHz low power, 192 MHz boost
// [R17] Four watchpoints and eight breakpoints
// [R18] Debugger reaches all memory and peripherals
// [R19] Code memory cached, data TIGHTLY_COUPLED_DATA_MEM local
// [R20] Shared SRAM, NVM, extended SRAM mapped
// [R21] APB peripherals add one wait state
// [R22] Reserved range answers bus error
module cadir_route
  import cadir_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  input  wire logic                        req_valid,
  input  wire logic [31:0]                 req_addr,
  input  wire logic                        req_fetch,
  input  wire logic                        req_priv,
  input  wire logic                        req_dbg,
  input  wire logic                        sys_prot_ok,
  output logic                             req_ready_reg,
  output logic                             resp_valid_reg,
  output cadir_pkg::cadir_target_t         target_reg,
  output logic                             ext_bus_en_reg,
  output logic                             cacheable_reg,
  output logic                             resp_fault_reg,
  output logic                             resp_buserr_reg,
  output logic [cadir_pkg::FS_W-1:0]       fault_status_reg,
  output logic [31:0]                      fault_addr_reg,
  input  wire logic                        fault_clr,
  input  wire logic                        mpu_wr,
  input  wire logic [2:0]                  mpu_idx,
  input  wire logic [31:0]                 mpu_lo,
  input  wire logic [31:0]                 mpu_hi,
  input  wire logic                        mpu_en,
  input  wire logic                        dbg_wr,
  input  wire logic                        dbg_watch,
  input  wire logic [2:0]                  dbg_idx,
  input  wire logic [31:0]                 dbg_addr,
  input  wire logic                        dbg_en,
  output logic                             watch_hit_reg,
  output logic                             break_hit_reg,
  input  wire logic [cadir_pkg::NUM_IRQ-1:0] irq_in,
  input  wire logic                        prio_wr,
  input  wire logic [4:0]                  prio_idx,
  input  wire logic [2:0]                  prio_val,
  input  wire logic                        vec_base_wr,
  input  wire logic [31:0]                 vec_base_data,
  input  wire logic                        deep_sleep,
  input  wire logic                        perf_mode_req,
  output logic [cadir_pkg::NUM_IRQ-1:0]    nested_irq_ctrl_irq_reg,
  output logic [cadir_pkg::NUM_IRQ-1:0]    wic_irq_reg,
  output logic                             wake_req_reg,
  output logic                             nmi_reg,
  output logic                             pend_valid_reg,
  output logic [4:0]                       pend_id_reg,
  output logic [31:0]                      vec_addr_reg,
  output logic [31:0]                      vec_base_reg,
  output logic                             perf_mode_reg,
  output logic [7:0]                       cpu_mhz_reg
);
  import cadir_pkg::*;

  // ***********************************
  // Decode and configuration storage
  // ***********************************
  cadir_target_t dec_tgt;
  logic          dec_exec;
  logic          dec_cache;
  logic          dec_apb;
  logic          acc;
  logic [31:0]   mpu_lo_reg [MPU_NREG];
  logic [31:0]   mpu_hi_reg [MPU_NREG];
  logic [31:0]   mpu_lo_next [MPU_NREG];
  logic [31:0]   mpu_hi_next [MPU_NREG];
  logic [MPU_NREG-1:0] mpu_en_reg, mpu_en_next;
  logic [29:0]   wp_reg [NUM_WATCH];
  logic [29:0]   wp_next [NUM_WATCH];
  logic [29:0]   bp_reg [NUM_BRK];
  logic [29:0]   bp_next [NUM_BRK];
  logic [NUM_WATCH-1:0] wp_en_reg, wp_en_next;
  logic [NUM_BRK-1:0]   bp_en_reg, bp_en_next;
  logic [PRIO_W-1:0]    prio_reg [NUM_IRQ];
  logic [PRIO_W-1:0]    prio_next [NUM_IRQ];
  logic [31:0]   vec_base_next;
  logic          perf_mode_next;
  logic [7:0]    cpu_mhz_next;

  cadir_addr_map u_map (
    .addr      (req_addr),
    .target    (dec_tgt),
    .exec_ok   (dec_exec),
    .cacheable (dec_cache),
    .apb_slow  (dec_apb)
  );

  assign acc = clk_en && req_valid && req_ready_reg;

  // Unprivileged hit on any enabled region faults; debugger bypasses
  function automatic logic mpu_violation(input logic [31:0] a);
    mpu_violation = 1'b0;
    for (int i = 0; i < MPU_NREG; i++) begin
      if (mpu_en_reg[i] && in_rng(a, mpu_lo_reg[i], mpu_hi_reg[i])) begin
        mpu_violation = 1'b1; // [R13]
      end
    end
  endfunction

  // Config writes, one entry per strobe
  always_comb begin
    mpu_lo_next    = mpu_lo_reg;
    mpu_hi_next    = mpu_hi_reg;
    mpu_en_next    = mpu_en_reg;
    wp_next        = wp_reg;
    bp_next        = bp_reg;
    wp_en_next     = wp_en_reg;
    bp_en_next     = bp_en_reg;
    prio_next      = prio_reg;
    vec_base_next  = vec_base_reg;
    perf_mode_next = perf_mode_req;
    cpu_mhz_next   = perf_mode_req ? HP_MHZ : LP_MHZ; // [R16]
    if (mpu_wr) begin
      mpu_lo_next[mpu_idx] = mpu_lo;
      mpu_hi_next[mpu_idx] = mpu_hi;
      mpu_en_next[mpu_idx] = mpu_en;
    end
    // Watch index wraps at four; upper index bit ignored [R17]
    if (dbg_wr && dbg_watch) begin
      wp_next[dbg_idx[1:0]]    = dbg_addr[31:2];
      wp_en_next[dbg_idx[1:0]] = dbg_en;
    end else if (dbg_wr) begin
      bp_next[dbg_idx]    = dbg_addr[31:2];
      bp_en_next[dbg_idx] = dbg_en;
    end
    if (prio_wr) begin
      prio_next[prio_idx] = prio_val; // [R11]
    end
    if (vec_base_wr) begin
      vec_base_next = vec_base_data & VTOR_MASK; // [R12]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < MPU_NREG; i++) begin
        mpu_lo_reg[i] <= 32'h0000_0000;
        mpu_hi_reg[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < NUM_WATCH; i++) begin
        wp_reg[i] <= 30'h0000_0000;
      end
      for (int i = 0; i < NUM_BRK; i++) begin
        bp_reg[i] <= 30'h0000_0000;
      end
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio_reg[i] <= 3'h0;
      end
      mpu_en_reg    <= 8'h00;
      wp_en_reg     <= 4'h0;
      bp_en_reg     <= 8'h00;
      vec_base_reg  <= VTOR_RST;
      perf_mode_reg <= 1'b0;
      cpu_mhz_reg   <= LP_MHZ;
    end else if (clk_en) begin
      mpu_lo_reg    <= mpu_lo_next;
      mpu_hi_reg    <= mpu_hi_next;
      mpu_en_reg    <= mpu_en_next;
      wp_reg        <= wp_next;
      bp_reg        <= bp_next;
      wp_en_reg     <= wp_en_next;
      bp_en_reg     <= bp_en_next;
      prio_reg      <= prio_next;
      vec_base_reg  <= vec_base_next;
      perf_mode_reg <= perf_mode_next;
      cpu_mhz_reg   <= cpu_mhz_next;
    end
  end

  // ***********************************
  // Access pipeline
  // ***********************************
  cadir_state_t  state_reg, state_next;
  logic          ready_next, rvalid_next, ebus_next, cache_next;
  logic          rfault_next, rberr_next, whit_next, bhit_next;
  logic          xn_hit, mpu_hit, sys_hit, bus_hit;
  cadir_target_t tgt_next;

  // Fault causes of the access being taken
  always_comb begin
    xn_hit  = req_fetch && !dec_exec && (dec_tgt != TGT_NONE); // [R1] [R6]
    mpu_hit = !req_dbg && !req_priv && mpu_violation(req_addr); // [R13] [R18]
    sys_hit = !sys_prot_ok; // [R15]
    bus_hit = (dec_tgt == TGT_NONE); // [R22]
  end

  // Fast targets and faulted accesses answer next cycle; unfaulted APB gets one extra wait cycle
  always_comb begin
    state_next  = state_reg;
    ready_next  = req_ready_reg;
    rvalid_next = 1'b0;
    tgt_next    = target_reg;
    ebus_next   = ext_bus_en_reg;
    cache_next  = cacheable_reg;
    rfault_next = resp_fault_reg;
    rberr_next  = resp_buserr_reg;
    whit_next   = 1'b0;
    bhit_next   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (acc) begin
          tgt_next    = dec_tgt;
          cache_next  = dec_cache;
          rfault_next = xn_hit || mpu_hit || sys_hit;
          rberr_next  = bus_hit;
          // Core-local space never leaves the core [R3]
          ebus_next   = !(xn_hit || mpu_hit || sys_hit || bus_hit) &&
                        (dec_tgt != TGT_CORE_PPB);
          ready_next  = 1'b0;
          for (int i = 0; i < NUM_WATCH; i++) begin
            whit_next |= !req_fetch && wp_en_reg[i] && (wp_reg[i] == req_addr[31:2]);
          end
          for (int i = 0; i < NUM_BRK; i++) begin
            bhit_next |= req_fetch && bp_en_reg[i] && (bp_reg[i] == req_addr[31:2]);
          end
          if (dec_apb && !rfault_next) begin
            state_next = ST_WAIT; // [R21]
          end else begin
            state_next  = ST_RESP;
            rvalid_next = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        state_next  = ST_RESP;
        rvalid_next = 1'b1;
      end
      ST_RESP: begin
        state_next = ST_IDLE;
        ready_next = 1'b1;
        ebus_next  = 1'b0;
      end
      default: begin
        state_next = ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg       <= ST_IDLE;
      req_ready_reg   <= 1'b1;
      resp_valid_reg  <= 1'b0;
      target_reg      <= TGT_NONE;
      ext_bus_en_reg  <= 1'b0;
      cacheable_reg   <= 1'b0;
      resp_fault_reg  <= 1'b0;
      resp_buserr_reg <= 1'b0;
      watch_hit_reg   <= 1'b0;
      break_hit_reg   <= 1'b0;
    end else if (clk_en) begin
      state_reg       <= state_next;
      req_ready_reg   <= ready_next;
      resp_valid_reg  <= rvalid_next;
      target_reg      <= tgt_next;
      ext_bus_en_reg  <= ebus_next;
      cacheable_reg   <= cache_next;
      resp_fault_reg  <= rfault_next;
      resp_buserr_reg <= rberr_next;
      watch_hit_reg   <= whit_next;
      break_hit_reg   <= bhit_next;
    end
  end

  // ***********************************
  // Fault status
  // ***********************************
  logic [FS_W-1:0] fstat_next, fset;
  logic [31:0]     faddr_next;

  // A new cause wins over a clear in the same cycle
  always_comb begin
    fset         = '0;
    fset[FS_XN]  = acc && xn_hit;
    fset[FS_MPU] = acc && mpu_hit;
    fset[FS_SYS] = acc && sys_hit;
    fset[FS_BUS] = acc && bus_hit;
    fstat_next   = (fault_clr ? '0 : fault_status_reg) | fset; // [R14]
    faddr_next   = (|fset) ? req_addr : fault_addr_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_status_reg <= '0;
      fault_addr_reg   <= 32'h0000_0000;
    end else if (clk_en) begin
      fault_status_reg <= fstat_next;
      fault_addr_reg   <= faddr_next;
    end
  end

  // ***********************************
  // Interrupt fan-out and arbitration
  // ***********************************
  logic        pvalid_next;
  logic [4:0]  pid_next;
  logic [31:0] vaddr_next;
  logic [2:0]  best;

  // Lowest level wins, then lowest index; only eight levels exist
  always_comb begin
    pvalid_next = 1'b0;
    pid_next    = pend_id_reg;
    best        = 3'h7;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_in[i] && (!pvalid_next || prio_reg[i] <= best)) begin // [R11]
        pvalid_next = 1'b1;
        best        = prio_reg[i];
        pid_next    = IRQ_IDW'(i);
      end
    end
    // Entry fetched from the relocated table [R12]
    vaddr_next = vec_base_reg + 32'((VEC_RSVD + int'(pid_next)) * 4);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nested_irq_ctrl_irq_reg   <= '0;
      wic_irq_reg    <= '0;
      wake_req_reg   <= 1'b0;
      nmi_reg        <= 1'b0;
      pend_valid_reg <= 1'b0;
      pend_id_reg    <= 5'h00;
      vec_addr_reg   <= 32'h0000_0000;
    end else if (clk_en) begin
      nested_irq_ctrl_irq_reg   <= irq_in; // [R8]
      wic_irq_reg    <= irq_in; // [R8]
      wake_req_reg   <= deep_sleep && (|irq_in); // [R9]
      nmi_reg        <= 1'b0; // [R10]
      pend_valid_reg <= pvalid_next;
      pend_id_reg    <= pid_next;
      vec_addr_reg   <= vaddr_next;
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  a_periph_route: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    acc && in_rng(req_addr, PERI_LO, PERI_HI) |=> target_reg == TGT_PERIPH)
    else $error("peripheral access misrouted");
  a_extmem_route: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    acc && req_fetch && in_rng(req_addr, EXTM_LO, EXTM_HI) |=>
    target_reg == TGT_EXTMEM && (!fault_status_reg[FS_XN] || $past(fault_status_reg[FS_XN])))
    else $error("external memory fetch refused");
  a_core_local: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    acc && in_rng(req_addr, PPB_LO, PPB_HI) |=> !ext_bus_en_reg ##1 !ext_bus_en_reg)
    else $error("core-local access forwarded");
  a_external_private_periph_bus_route: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    acc && in_rng(req_addr, EXTERNAL_PRIVATE_PERIPH_BUS_LO, EXTERNAL_PRIVATE_PERIPH_BUS_HI) |=> target_reg == TGT_EXTERNAL_PRIVATE_PERIPH_BUS)
    else $error("upper private access misrouted");
  a_xn_fetch: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    acc && req_fetch && (req_addr >= PPB_LO) |=>
    resp_fault_reg && fault_status_reg[FS_XN] && !ext_bus_en_reg)
    else $error("fetch from private range not faulted");
  a_vsys_route: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    acc && !req_fetch && in_rng(req_addr, VSYS_LO, VSYS_HI) |=> target_reg == TGT_SYSAHB)
    else $error("vendor range access misrouted");
  a_irq_fanout: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    clk_en |=> nested_irq_ctrl_irq_reg == $past(irq_in) && wic_irq_reg == nested_irq_ctrl_irq_reg)
    else $error("interrupt fan-out mismatch");
  a_wake_req: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    clk_en && deep_sleep && (irq_in != '0) |=> wake_req_reg)
    else $error("interrupt did not wake core");
  a_no_nmi: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    !nmi_reg) else $error("non-maskable interrupt raised");
  a_apb_wait: assert property (@(posedge clk) disable iff (!resetn) // [R21]
    acc && in_rng(req_addr, APB_LO, APB_HI) && !(xn_hit || mpu_hit || sys_hit) |=>
    !resp_valid_reg && state_reg == ST_WAIT)
    else $error("apb access missing wait state");
  a_rsvd_err: assert property (@(posedge clk) disable iff (!resetn) // [R22]
    acc && in_rng(req_addr, RSVD_LO, RSVD_HI) |=> resp_valid_reg && resp_buserr_reg)
    else $error("reserved access not errored");
  a_sys_prot: assert property (@(posedge clk) disable iff (!resetn) // [R15]
    acc && !sys_prot_ok |=> resp_fault_reg && fault_status_reg[FS_SYS])
    else $error("system protection ignored");
endmodule // cadir_route

// File: bench/cadir_irq_src.sv
`timescale 1ns/1ns
// ************************
// Peripheral interrupt source model
// ************************
module cadir_irq_src (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [31:0] level_in,
  output logic      [31:0] irq_out
);
  // Sources change their lines just after an edge, like flops would
  // No non-maskable line exists on this side at all
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_out <= 32'h0;
    end else begin
      irq_out <= level_in;
    end
  end
endmodule // cadir_irq_src

// File: bench/cadir_route_tb.sv
`timescale 1ns/1ns
module cadir_route_tb;
  import cadir_pkg::*;
  // ************************
  // Stimulus, observed outputs, bench state
  // ************************
  logic          clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, req_valid = 1'b0;
  logic          req_fetch = 1'b0, req_priv = 1'b1, req_dbg = 1'b0, sys_prot_ok = 1'b1;
  logic          fault_clr = 1'b0, mpu_wr = 1'b0, mpu_en = 1'b0, dbg_wr = 1'b0;
  logic          dbg_watch = 1'b0, dbg_en = 1'b0, prio_wr = 1'b0, vec_base_wr = 1'b0;
  logic          deep_sleep = 1'b0, perf_mode_req = 1'b0;
  logic [2:0]    mpu_idx = 3'h0, dbg_idx = 3'h0, prio_val = 3'h0;
  logic [4:0]    prio_idx = 5'h0;
  logic [31:0]   req_addr = 32'h0, mpu_lo = 32'h0, mpu_hi = 32'h0, dbg_addr = 32'h0;
  logic [31:0]   vec_base_data = 32'h0, lvl = 32'h0, irq_in, r;
  logic          req_ready_reg, resp_valid_reg, ext_bus_en_reg, cacheable_reg;
  logic          resp_fault_reg, resp_buserr_reg, watch_hit_reg, break_hit_reg;
  logic          wake_req_reg, nmi_reg, pend_valid_reg, perf_mode_reg;
  cadir_target_t target_reg;
  logic [3:0]    fault_status_reg, fs_exp = 4'h0;
  logic [4:0]    pend_id_reg;
  logic [7:0]    cpu_mhz_reg;
  logic [31:0]   fault_addr_reg, nested_irq_ctrl_irq_reg, wic_irq_reg, vec_addr_reg, vec_base_reg;
  int            mismatches = 0, num_checks = 0, cyc = 0;
  int unsigned   rs = 87;
  logic [31:0]   ta [13] = '{32'h4000_0000, 32'h4007_FFFF, 32'h5FFF_FFFF, 32'h6000_0100,
    32'h9FFF_FFFF, 32'hE004_3FFF, 32'hE004_4000, 32'hE000_0000, 32'hE010_0000,
    32'hFFFF_FFFF, 32'h2000_0000, 32'h3FFF_FFFF, 32'h6000_0000};
  logic          tf [13] = '{0, 0, 1, 1, 0, 0, 0, 1, 0, 1, 0, 1, 0};

  cadir_irq_src src_u (.clk, .resetn, .level_in(lvl), .irq_out(irq_in));
  cadir_route dut_u (.clk, .resetn, .clk_en, .req_valid, .req_addr, .req_fetch, .req_priv,
    .req_dbg, .sys_prot_ok, .req_ready_reg, .resp_valid_reg, .target_reg, .ext_bus_en_reg,
    .cacheable_reg, .resp_fault_reg, .resp_buserr_reg, .fault_status_reg, .fault_addr_reg,
    .fault_clr, .mpu_wr, .mpu_idx, .mpu_lo, .mpu_hi, .mpu_en, .dbg_wr, .dbg_watch, .dbg_idx,
    .dbg_addr, .dbg_en, .watch_hit_reg, .break_hit_reg, .irq_in, .prio_wr, .prio_idx,
    .prio_val, .vec_base_wr, .vec_base_data, .deep_sleep, .perf_mode_req, .nested_irq_ctrl_irq_reg,
    .wic_irq_reg, .wake_req_reg, .nmi_reg, .pend_valid_reg, .pend_id_reg, .vec_addr_reg,
    .vec_base_reg, .perf_mode_reg, .cpu_mhz_reg);

  // Free-running clock and a hang guard sized well above the planned traffic
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      final_report;
    end
  end

  // ************************
  // Shared tasks and the reference map
  // ************************
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // Valid only above the code region; the bench never goes below it
  function automatic cadir_target_t tgt_of(input logic [31:0] a);
    if (a < 32'h4000_0000) return TGT_NONE;
    if (a < 32'h6000_0000) return TGT_PERIPH;
    if (a < 32'hA000_0000) return TGT_EXTMEM;
    if (a < 32'hE000_0000) return TGT_EXTDEV;
    if (a < 32'hE004_4000) return TGT_CORE_PPB;
    if (a < 32'hE010_0000) return TGT_EXTERNAL_PRIVATE_PERIPH_BUS;
    return TGT_SYSAHB;
  endfunction

  // A gap edge after the drop, so back-to-back strobes never collide in one step
  task automatic strobe(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic acc(input logic [31:0] a, input logic f, p, d, s);
    cadir_target_t t;
    logic          be, xn, mp, fl, bh, wh;
    int            n;
    t = tgt_of(a);
    be = (t == TGT_NONE);
    xn = f && !be && t != TGT_EXTMEM;
    mp = !d && !p && a >= 32'h6000_0000 && a <= 32'h6000_FFFF;
    fl = xn || mp || !s;
    fs_exp |= {be, !s, mp, xn};
    bh = 1'b0;
    wh = 1'b0;
    n = 0;
    @(posedge clk);
    #1 {req_valid, req_addr, req_fetch, req_priv, req_dbg, sys_prot_ok} = {1'b1, a, f, p, d, s};
    // Fast answers and hit pulses stand from the accept edge, so look there first; unfaulted APB answers one edge later
    @(posedge clk);
    #1 req_valid = 1'b0;
    n = 1;
    bh = break_hit_reg;
    wh = watch_hit_reg;
    while (resp_valid_reg !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, (!fl && a >= 32'h4000_0000 && a <= 32'h4007_FFFF) ? 2 : 1);
    chk(resp_buserr_reg, be);
    chk(resp_fault_reg, fl);
    if (!be) chk(target_reg, t);
    if (!fl && t == TGT_CORE_PPB) chk(ext_bus_en_reg, 0);
    if (!fl && (t == TGT_EXTERNAL_PRIVATE_PERIPH_BUS || t == TGT_SYSAHB)) chk(ext_bus_en_reg, 1);
    chk(cacheable_reg, 0);
    chk(fault_status_reg, fs_exp);
    if (fl || be) chk(fault_addr_reg, a);
    chk(bh, f && a[31:2] == 30'h1800_0040);
    chk(wh, !f && a[31:2] == 30'h3804_0000);
    @(posedge clk);
    #1 chk(resp_valid_reg, 0);
  endtask

  // ************************
  // Main sequence
  // ************************
  initial begin
    repeat (20) @(posedge clk);
    #1 chk(req_ready_reg, 1);
    chk(cpu_mhz_reg, 32'h60);
    chk(vec_base_reg, 0);
    resetn = 1'b1;
    {mpu_idx, mpu_lo, mpu_hi, mpu_en} = {3'h3, 32'h6000_0000, 32'h6000_FFFF, 1'b1};
    strobe(mpu_wr);
    {dbg_idx, dbg_addr, dbg_en} = {3'h7, 32'h6000_0100, 1'b1};
    strobe(dbg_wr);
    {dbg_watch, dbg_idx, dbg_addr} = {1'b1, 3'h0, 32'hE010_0000};
    strobe(dbg_wr);
    for (int i = 0; i < 13; i++) acc(ta[i], tf[i], i != 12, 1'b0, 1'b1);
    acc(32'h6000_FFFF, 1'b0, 1'b0, 1'b1, 1'b1);
    acc(32'h4008_0000, 1'b0, 1'b1, 1'b0, 1'b0);
    strobe(fault_clr);
    fs_exp = 4'h0;
    chk(fault_status_reg, 0);
    // Random traffic; reserved space is kept clear of the system check
    for (int i = 0; i < 300; i++) begin
      r = rnd() | 32'h2000_0000;
      acc(r, r[0], r[1], r[2], (|r[5:3]) || r < 32'h4000_0000);
    end
    for (int i = 0; i < 20; i++) begin
      r = rnd();
      lvl = r & {32{r[9]}};
      deep_sleep = r[7];
      repeat (3) @(posedge clk);
      #1 chk(nested_irq_ctrl_irq_reg, lvl);
      chk(wic_irq_reg, lvl);
      chk(wake_req_reg, deep_sleep && (|lvl));
      chk(nmi_reg, 0);
    end
    lvl = 32'h0;
    {prio_idx, prio_val} = {5'h2, 3'h7};
    strobe(prio_wr);
    {prio_idx, prio_val} = {5'h9, 3'h0};
    strobe(prio_wr);
    // Base stays in TCM, never inside the private range
    vec_base_data = 32'h1000_00FF;
    strobe(vec_base_wr);
    chk(vec_base_reg, 32'h1000_0080);
    lvl = 32'h0000_0204;
    repeat (4) @(posedge clk);
    #1 chk(pend_valid_reg, 1);
    chk(pend_id_reg, 9);
    chk(vec_addr_reg, 32'h1000_00E4);
    perf_mode_req = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(cpu_mhz_reg, 32'hC0);
    chk(perf_mode_reg, 1);
    perf_mode_req = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(cpu_mhz_reg, 32'h60);
    chk(perf_mode_reg, 0);
    final_report;
  end
endmodule // cadir_route_tb
